// ---- vct_defs.svh ----
`ifndef VCT_DEFS_SVH
`define VCT_DEFS_SVH

// task numbers seen by the scheduler
`define VCT_TASK_INPUT 4'h2
`define VCT_TASK_PHASE 4'h3
`define VCT_TASK_COORD 4'h4
`define VCT_TASK_ATAN 4'hC
`define VCT_TASK_SQRT 4'hD

// wishbone byte offsets
`define VCT_OFS_CTRL 8'h00
`define VCT_OFS_TASK 8'h04
`define VCT_OFS_PHA 8'h08
`define VCT_OFS_PHB 8'h0C
`define VCT_OFS_PHC 8'h10
`define VCT_OFS_ALPHA 8'h14
`define VCT_OFS_BETA 8'h18
`define VCT_OFS_SCRATCH 8'h1C
`define VCT_OFS_DAXIS 8'h20
`define VCT_OFS_QAXIS 8'h24
`define VCT_OFS_SINE 8'h28
`define VCT_OFS_COSINE 8'h2C
`define VCT_OFS_VDC 8'h30

// control register fields
`define VCT_CTRL_ATAN 0
`define VCT_CTRL_MODE_LO 1
`define VCT_CTRL_MODE_HI 2
`define VCT_CTRL_SHIFT2 3
`define VCT_CTRL_PHDIS 4
`define VCT_CTRL_RESET 5'h00

// task register status fields
`define VCT_TASK_ID_HI 3
`define VCT_TASK_BUSY 8

// fixed-point constants, iteration bounds and the PWM timer channel
`define VCT_Q31_MAX 32'h7FFF_FFFF
`define VCT_Q31_MIN 32'h8000_0000
`define VCT_INV_SQRT3 33'h0_49E6_9D16
`define VCT_ATAN_MAX 32'h0000_2000
`define VCT_ATAN_MIN 32'hFFFF_E000
`define VCT_Q15_SHIFT 15
`define VCT_Q31_SHIFT 31
`define VCT_SQRT_LIMIT 32'h0002_0000
`define VCT_SQRT_TOP 5'h10
`define VCT_CORDIC_LAST 5'h0D
`define VCT_PWM_CHANNEL 2'h1

`endif

// ---- vct_pkg.sv ----
package vct_pkg;

typedef enum logic [2:0] {
	vct_idle,
	vct_input,
	vct_phase,
	vct_coord,
	vct_wait_math
} vct_state_t;

typedef enum logic {
	vct_op_sqrt,
	vct_op_atan
} vct_op_t;

typedef struct packed {
	logic busy;
	vct_op_t op;
	logic [4:0] cnt;
	logic signed [33:0] x;
	logic signed [33:0] y;
	logic signed [31:0] z;
	logic [16:0] root;
	logic [32:0] rad;
	logic [31:0] result;
	logic done;
} vct_math_t;

typedef struct packed {
	vct_state_t state;
	logic [4:0] ctrl;
	logic [3:0] last_task;
	logic [31:0] pha;
	logic [31:0] phb;
	logic [31:0] phc;
	logic [31:0] alpha;
	logic [31:0] beta;
	logic [31:0] scratch;
	logic [31:0] daxis;
	logic [31:0] qaxis;
	logic [15:0] sine;
	logic [15:0] cosine;
	logic [15:0] vdc;
	logic ack;
	logic [31:0] rdata;
} vct_regs_t;

endpackage : vct_pkg

// ---- vct_math.sv ----
`timescale 1ns/1ns
`include "vct_defs.svh"

module vct_math (
	input wire logic clk,
	input wire logic rst,
	input wire logic start,
	input wire vct_pkg::vct_op_t op,
	input wire logic signed [31:0] num,
	input wire logic signed [31:0] den,
	output logic done,
	output logic [31:0] result
);

	vct_pkg::vct_math_t r;
	vct_pkg::vct_math_t next_r;

	// atan(2^-i) with 45 degrees = 8192
	function automatic logic signed [31:0] atan_step(input logic [4:0] i);
		case (i)
			5'h00: atan_step = 32'sh0000_2000;
			5'h01: atan_step = 32'sh0000_12E4;
			5'h02: atan_step = 32'sh0000_09FB;
			5'h03: atan_step = 32'sh0000_0511;
			5'h04: atan_step = 32'sh0000_028B;
			5'h05: atan_step = 32'sh0000_0146;
			5'h06: atan_step = 32'sh0000_00A3;
			5'h07: atan_step = 32'sh0000_0051;
			5'h08: atan_step = 32'sh0000_0029;
			5'h09: atan_step = 32'sh0000_0014;
			5'h0A: atan_step = 32'sh0000_000A;
			5'h0B: atan_step = 32'sh0000_0005;
			5'h0C: atan_step = 32'sh0000_0003;
			default: atan_step = 32'sh0000_0001;
		endcase
	endfunction : atan_step

	always_comb begin
		logic signed [32:0] an;
		logic signed [32:0] ad;
		logic [16:0] trial;
		logic [33:0] sq;
		next_r = r;
		an = 33'(num);
		ad = 33'(den);
		trial = 17'h0_0000;
		sq = 34'h0_0000_0000;
		next_r.done = 1'b0;
		if (an < 0)
			an = -an;
		if (ad < 0)
			ad = -ad;
		if (start && !r.busy) begin
			next_r.op = op;
			next_r.z = 32'sh0000_0000;
			next_r.root = 17'h0_0000;
			if (op == vct_pkg::vct_op_sqrt) begin
				next_r.busy = 1'b1;
				next_r.cnt = `VCT_SQRT_TOP;
				// inputs above 4.0 are clamped so the root saturates at 2.0
				if (num > $signed(`VCT_SQRT_LIMIT) || num < 0)
					next_r.rad = 33'({`VCT_SQRT_LIMIT, 15'h0000});
				else
					next_r.rad = {num[17:0], 15'h0000};
				if (num < 0)
					next_r.rad = 33'h0_0000_0000;
			end else if (an > ad) begin
				// ratio beyond +-1: clamp to +-45 degrees
				next_r.done = 1'b1;
				next_r.result = ((num < 0) != (den < 0)) ?
					`VCT_ATAN_MIN : `VCT_ATAN_MAX;
			end else begin
				next_r.busy = 1'b1;
				next_r.cnt = 5'h00;
				// mirror into the right half plane; atan(y/x) is unchanged
				next_r.x = (den < 0) ? -34'(den) : 34'(den);
				next_r.y = (den < 0) ? -34'(num) : 34'(num);
			end
		end else if (r.busy) begin
			if (r.op == vct_pkg::vct_op_sqrt) begin
				trial = r.root | (17'h0_0001 << r.cnt);
				sq = 34'(trial) * 34'(trial);
				if (sq <= 34'(r.rad))
					next_r.root = trial;
				if (r.cnt == 5'h00) begin
					next_r.busy = 1'b0;
					next_r.done = 1'b1;
					next_r.result = 32'(next_r.root);
				end else
					next_r.cnt = r.cnt - 5'h01;
			end else begin
				if (r.y >= 0) begin
					next_r.x = r.x + (r.y >>> r.cnt);
					next_r.y = r.y - (r.x >>> r.cnt);
					next_r.z = r.z + atan_step(r.cnt);
				end else begin
					next_r.x = r.x - (r.y >>> r.cnt);
					next_r.y = r.y + (r.x >>> r.cnt);
					next_r.z = r.z - atan_step(r.cnt);
				end
				next_r.cnt = r.cnt + 5'h01;
				if (r.cnt == `VCT_CORDIC_LAST) begin
					next_r.busy = 1'b0;
					next_r.done = 1'b1;
					next_r.result = next_r.z;
				end
			end
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst)
			r <= '0;
		else
			r <= next_r;
	end

	assign done = r.done;
	assign result = r.result;

endmodule : vct_math

// ---- vct_engine.sv ----
// Our own choices: the register offsets and the Wishbone slave port.
`timescale 1ns/1ns
`include "vct_defs.svh"

module vct_engine (
	input wire logic clk,
	input wire logic rst,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	input wire logic [15:0] adc_result_slot0,
	input wire logic [15:0] adc_result_slot1,
	input wire logic [15:0] adc_result_slot2,
	input wire logic [15:0] adc_result_slot3,
	output logic [1:0] pwm_timer_unit_sel,
	output logic engine_busy
);

	vct_pkg::vct_regs_t r;
	vct_pkg::vct_regs_t next_r;
	logic math_start;
	vct_pkg::vct_op_t math_op;
	logic signed [31:0] math_num;
	logic signed [31:0] math_den;
	logic math_done;
	logic [31:0] math_result;

	function automatic logic [31:0] sat32(input logic signed [65:0] v);
		if (&v[65:31] || ~|v[65:31])
			sat32 = v[31:0];
		else
			sat32 = v[65] ? `VCT_Q31_MIN : `VCT_Q31_MAX;
	endfunction : sat32

	// Q15 by Q31 product, rescaled to Q31 but kept wide for the sum
	function automatic logic signed [48:0] mul_q15(input logic [15:0] a,
		input logic [31:0] b);
		logic signed [47:0] p;
		p = $signed(a) * $signed(b);
		mul_q15 = 49'(p >>> `VCT_Q15_SHIFT);
	endfunction : mul_q15

	// offset-binary 12-bit result to a signed Q31 current
	function automatic logic [31:0] adc_to_q31(input logic [15:0] s);
		adc_to_q31 = {~s[15], s[14:4], 20'h0_0000};
	endfunction : adc_to_q31

	function automatic logic [31:0] wmask(input logic [31:0] old,
		input logic [31:0] d, input logic [3:0] sel);
		for (int i = 0; i < 4; i++) begin
			if (sel[i])
				old[i*8 +: 8] = d[i*8 +: 8];
		end
		wmask = old;
	endfunction : wmask

	always_comb begin
		logic acc;
		logic wr;
		logic start_ok;
		logic signed [32:0] diff;
		logic signed [65:0] prod;
		logic signed [49:0] sum;
		logic [31:0] rd;
		logic [3:0] cmd;
		next_r = r;
		acc = wb_cyc_i && wb_stb_i;
		wr = acc && wb_we_i && r.ack;
		start_ok = 1'b0;
		diff = 33'sh0_0000_0000;
		prod = 66'sh0;
		sum = 50'sh0;
		rd = 32'h0000_0000;
		cmd = wb_dat_i[`VCT_TASK_ID_HI:0];
		math_start = 1'b0;
		math_op = vct_pkg::vct_op_sqrt;
		math_num = r.scratch;
		math_den = `VCT_Q31_MAX;

		// registered ack: one wait state, dropped the cycle after
		next_r.ack = acc && !r.ack;
		case (wb_adr_i)
			`VCT_OFS_CTRL: rd = 32'(r.ctrl);
			`VCT_OFS_TASK: rd = {23'h00_0000, r.state != vct_pkg::vct_idle,
				4'h0, r.last_task};
			`VCT_OFS_PHA: rd = r.pha;
			`VCT_OFS_PHB: rd = r.phb;
			`VCT_OFS_PHC: rd = r.phc;
			`VCT_OFS_ALPHA: rd = r.alpha;
			`VCT_OFS_BETA: rd = r.beta;
			`VCT_OFS_SCRATCH: rd = r.scratch;
			`VCT_OFS_DAXIS: rd = r.daxis;
			`VCT_OFS_QAXIS: rd = r.qaxis;
			`VCT_OFS_SINE: rd = {16'h0000, r.sine};
			`VCT_OFS_COSINE: rd = {16'h0000, r.cosine};
			`VCT_OFS_VDC: rd = {16'h0000, r.vdc};
			default: rd = 32'h0000_0000;
		endcase
		if (acc && !r.ack)
			next_r.rdata = rd;

		if (wr) begin
			case (wb_adr_i)
				`VCT_OFS_CTRL: next_r.ctrl = 5'(wmask(32'(r.ctrl),
					wb_dat_i, wb_sel_i));
				`VCT_OFS_TASK: start_ok = wb_sel_i[0];
				`VCT_OFS_PHA: next_r.pha = wmask(r.pha, wb_dat_i, wb_sel_i);
				`VCT_OFS_PHB: next_r.phb = wmask(r.phb, wb_dat_i, wb_sel_i);
				`VCT_OFS_PHC: next_r.phc = wmask(r.phc, wb_dat_i, wb_sel_i);
				`VCT_OFS_ALPHA: next_r.alpha = wmask(r.alpha, wb_dat_i,
					wb_sel_i);
				`VCT_OFS_BETA: next_r.beta = wmask(r.beta, wb_dat_i, wb_sel_i);
				`VCT_OFS_SCRATCH: next_r.scratch = wmask(r.scratch, wb_dat_i,
					wb_sel_i);
				`VCT_OFS_DAXIS: next_r.daxis = wmask(r.daxis, wb_dat_i,
					wb_sel_i);
				`VCT_OFS_QAXIS: next_r.qaxis = wmask(r.qaxis, wb_dat_i,
					wb_sel_i);
				`VCT_OFS_SINE: next_r.sine = 16'(wmask(32'(r.sine), wb_dat_i,
					wb_sel_i));
				`VCT_OFS_COSINE: next_r.cosine = 16'(wmask(32'(r.cosine),
					wb_dat_i, wb_sel_i));
				default: ;
			endcase
		end

		case (r.state)
			vct_pkg::vct_idle: begin
				// commands while a task runs are dropped, not queued
				if (start_ok) begin
					case (cmd)
						`VCT_TASK_INPUT: next_r.state = vct_pkg::vct_input;
						`VCT_TASK_PHASE: next_r.state = vct_pkg::vct_phase;
						`VCT_TASK_COORD: next_r.state = vct_pkg::vct_coord;
						`VCT_TASK_ATAN: begin
							math_start = 1'b1;
							math_op = vct_pkg::vct_op_atan;
							next_r.state = vct_pkg::vct_wait_math;
						end
						`VCT_TASK_SQRT: begin
							math_start = 1'b1;
							next_r.state = vct_pkg::vct_wait_math;
						end
						default: ;
					endcase
					if (next_r.state != vct_pkg::vct_idle)
						next_r.last_task = cmd;
				end
			end
			vct_pkg::vct_input: begin
				next_r.pha = adc_to_q31(adc_result_slot0);
				next_r.phb = adc_to_q31(adc_result_slot1);
				next_r.vdc = adc_result_slot3;
				// 1x mode without shift 2: third current from a+b+c = 0
				if (r.ctrl[`VCT_CTRL_MODE_HI] && !r.ctrl[`VCT_CTRL_SHIFT2])
					next_r.phc = sat32(-(66'(signed'(next_r.pha)) +
						66'(signed'(next_r.phb))));
				else
					next_r.phc = adc_to_q31(adc_result_slot2);
				next_r.state = vct_pkg::vct_idle;
			end
			vct_pkg::vct_phase: begin
				if (!r.ctrl[`VCT_CTRL_PHDIS]) begin
					next_r.alpha = r.pha;
					diff = 33'(signed'(r.phb)) - 33'(signed'(r.phc));
					prod = 66'(diff) * 66'(signed'(`VCT_INV_SQRT3));
					next_r.beta = sat32(prod >>> `VCT_Q31_SHIFT);
				end
				next_r.state = vct_pkg::vct_idle;
			end
			vct_pkg::vct_coord: begin
				sum = 50'(mul_q15(r.cosine, r.alpha)) +
					50'(mul_q15(r.sine, r.beta));
				next_r.daxis = sat32(66'(sum));
				sum = 50'(mul_q15(r.cosine, r.beta)) -
					50'(mul_q15(r.sine, r.alpha));
				next_r.qaxis = sat32(66'(sum));
				if (r.ctrl[`VCT_CTRL_ATAN]) begin
					math_start = 1'b1;
					math_op = vct_pkg::vct_op_atan;
					math_num = next_r.daxis;
					math_den = next_r.qaxis;
					next_r.state = vct_pkg::vct_wait_math;
				end else
					next_r.state = vct_pkg::vct_idle;
			end
			vct_pkg::vct_wait_math: begin
				if (math_done) begin
					next_r.scratch = math_result;
					next_r.state = vct_pkg::vct_idle;
				end
			end
			default: next_r.state = vct_pkg::vct_idle;
		endcase
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst)
			r <= '0;
		else
			r <= next_r;
	end

	vct_math u_math (
		.clk(clk),
		.rst(rst),
		.start(math_start),
		.op(math_op),
		.num(math_num),
		.den(math_den),
		.done(math_done),
		.result(math_result)
	);

	assign wb_dat_o = r.rdata;
	assign wb_ack_o = r.ack;
	assign pwm_timer_unit_sel = `VCT_PWM_CHANNEL;
	assign engine_busy = r.state != vct_pkg::vct_idle;

endmodule : vct_engine

// ---- vct_engine_properties.sv ----
`timescale 1ns/1ns
module vct_props (
	input wire logic clk,
	input wire logic rst,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic wb_ack_o,
	input wire logic [1:0] pwm_timer_unit_sel,
	input wire logic engine_busy
);
	default clocking @(posedge clk);
	endclocking
	default disable iff (rst);
	logic req;
	logic go;
	logic [3:0] id;
	assign req = wb_cyc_i && wb_stb_i;
	// a task write that the idle engine accepts
	assign go = wb_ack_o && wb_we_i && wb_adr_i == 8'h04 && wb_sel_i[0]
		&& !engine_busy;
	assign id = wb_dat_i[3:0];
	a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack held too long");
	a_ack_answer: assert property (req && !wb_ack_o |=> wb_ack_o)
		else $error("request not acked");
	a_ack_cause: assert property (!req |=> !wb_ack_o)
		else $error("ack without request");
	a_timer_pair: assert property (pwm_timer_unit_sel == 2'h1)
		else $error("wrong timer channel");
	a_busy_cause: assert property ($rose(engine_busy) |-> $past(go))
		else $error("busy without task");
	a_short_task: assert property (go && id inside {4'h2, 4'h3}
		|=> engine_busy ##1 !engine_busy) else $error("short task length");
	a_unknown_id: assert property (go && !(id inside {4'h2, 4'h3, 4'h4,
		4'hC, 4'hD}) |=> !engine_busy) else $error("unknown task ran");
	a_root_time: assert property (go && id == 4'hD
		|=> engine_busy[*8] ##1 engine_busy[*8] ##[1:3] !engine_busy)
		else $error("root task length");
	a_atan_time: assert property (go && id == 4'hC
		|=> engine_busy ##[1:15] !engine_busy) else $error("atan length");
	a_hole_zero: assert property (wb_ack_o && !wb_we_i && wb_adr_i >= 8'h34
		|-> wb_dat_o == 32'h0000_0000) else $error("hole reads nonzero");
	a_dat_hold: assert property (!wb_ack_o |-> $stable(wb_dat_o))
		else $error("read data moved");
	c_root: cover property (go && id == 4'hD);
	c_atan: cover property (go && id == 4'hC);
	c_phase: cover property (go && id == 4'h3);
endmodule : vct_props
bind vct_engine vct_props i_props (.clk, .rst, .wb_cyc_i, .wb_stb_i,
	.wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o,
	.pwm_timer_unit_sel, .engine_busy);

// ---- vct_engine_tb.sv ----
`timescale 1ns/1ns
module vct_engine_tb;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic cyc = 1'b0;
	logic stb = 1'b0;
	logic we = 1'b0;
	logic [7:0] adr = 8'h00;
	logic [3:0] sel = 4'h0;
	logic [31:0] dat = 32'h0000_0000;
	logic [31:0] rdat;
	logic [31:0] v;
	logic ack;
	logic busy;
	logic [1:0] tmr;
	logic [15:0] s0 = 16'h0000;
	logic [15:0] s1 = 16'h0000;
	logic [15:0] s2 = 16'h0000;
	logic [15:0] s3 = 16'h0000;
	logic [31:0] md[4] = '{32'h0000_0000, 32'h0000_0002, 32'h0000_0004,
		32'h0000_000C};
	logic [31:0] cx[4] = '{32'h1000_0000, 32'h1000_0000, 32'hE000_0000,
		32'h1000_0000};
	logic [31:0] rq[3] = '{32'h0002_0000, 32'h0001_0000, 32'h0000_0001};
	logic [31:0] aq[4] = '{32'h7FFF_FFFF, 32'h8000_0000, 32'h4000_0000,
		32'h0000_0000};
	int n_fail = 0;
	int compares = 0;
	int ticks = 0;
	always #5 clk = ~clk;
	vct_engine i_dut (.clk, .rst, .wb_cyc_i(cyc), .wb_stb_i(stb),
		.wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat),
		.wb_dat_o(rdat), .wb_ack_o(ack), .adc_result_slot0(s0),
		.adc_result_slot1(s1), .adc_result_slot2(s2), .adc_result_slot3(s3),
		.pwm_timer_unit_sel(tmr), .engine_busy(busy));
	task automatic finish_test;
		$display("mismatches %0d compares %0d", n_fail, compares);
		if (n_fail == 0 && compares > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : finish_test
	// holds the request until ack is sampled, then releases
	task automatic bus(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		@(posedge clk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		dat <= d;
		sel <= 4'hF;
		do @(posedge clk); while (ack !== 1'b1);
		v = rdat;
		cyc <= 1'b0;
		stb <= 1'b0;
	endtask : bus
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		bus(1'b1, a, d);
	endtask : wr
	task automatic rc(input logic [7:0] a, input logic [31:0] e);
		bus(1'b0, a, 32'h0000_0000);
		compares++;
		if (v !== e) begin
			n_fail++;
			$display("BAD reg %h exp %h got %h", a, e, v);
		end
	endtask : rc
	task automatic cp(input logic [31:0] e, input logic [31:0] g);
		compares++;
		if (g !== e) begin
			n_fail++;
			$display("BAD pin exp %h got %h", e, g);
		end
	endtask : cp
	// fixed-point results may differ from the ideal by a few counts
	task automatic rn(input logic [7:0] a, input real e, input int t);
		logic signed [31:0] x;
		logic signed [32:0] df;
		bus(1'b0, a, 32'h0000_0000);
		x = $rtoi(e);
		df = $signed(v) - x;
		compares++;
		if (^v === 1'bx || df > t || df < -t) begin
			n_fail++;
			$display("BAD reg %h exp %h got %h", a, x, v);
		end
	endtask : rn
	task automatic idle;
		@(posedge clk);
		#1;
		while (busy !== 1'b0) begin
			@(posedge clk);
			#1;
		end
	endtask : idle
	task automatic run(input logic [3:0] id);
		wr(8'h04, {28'h000_0000, id});
		idle();
	endtask : run
	always @(posedge clk) begin
		ticks++;
		if (ticks == 5000) begin
			n_fail++;
			finish_test();
		end
	end
	initial begin
		repeat (12) @(posedge clk);
		rst <= 1'b0;
		rc(8'h00, 32'h0000_0000);
		rc(8'h40, 32'h0000_0000);
		cp(32'h0000_0001, 32'(tmr));
		s0 <= 16'hC000;
		s1 <= 16'h6000;
		s2 <= 16'h9000;
		s3 <= 16'h1234;
		foreach (md[i]) begin
			wr(8'h00, md[i]);
			run(4'h2);
			rc(8'h08, 32'h4000_0000);
			rc(8'h0C, 32'hE000_0000);
			rc(8'h10, cx[i]);
		end
		rc(8'h30, 32'h0000_1234);
		wr(8'h00, 32'h0000_0000);
		wr(8'h08, 32'h4000_0000);
		wr(8'h0C, 32'h2000_0000);
		run(4'h3);
		rc(8'h14, 32'h4000_0000);
		rn(8'h18, 0.125 / $sqrt(3.0) * 2.0 ** 31, 4);
		wr(8'h0C, 32'h7FFF_FFFF);
		wr(8'h10, 32'h8000_0000);
		run(4'h3);
		rc(8'h18, 32'h7FFF_FFFF);
		// a task issued while the root runs must be dropped
		wr(8'h1C, 32'h0000_2000);
		wr(8'h04, 32'h0000_000D);
		wr(8'h08, 32'h1000_0000);
		wr(8'h04, 32'h0000_0003);
		rc(8'h04, 32'h0000_010D);
		idle();
		wr(8'h04, 32'h0000_0007);
		rc(8'h14, 32'h4000_0000);
		rc(8'h1C, 32'h0000_4000);
		rc(8'h04, 32'h0000_000D);
		foreach (rq[i]) begin
			wr(8'h1C, rq[i]);
			run(4'hD);
			rn(8'h1C, $floor($sqrt(rq[i] * 32768.0)), 1);
		end
		wr(8'h1C, 32'h0003_0000);
		run(4'hD);
		rc(8'h1C, 32'h0001_0000);
		foreach (aq[i]) begin
			wr(8'h1C, aq[i]);
			run(4'hC);
			rn(8'h1C, $atan($signed(aq[i]) / 2.0 ** 31) / $atan(1.0) * 8192.0,
				8);
		end
		wr(8'h14, 32'h4000_0000);
		wr(8'h18, 32'h2000_0000);
		wr(8'h28, 32'h0000_4000);
		wr(8'h2C, 32'h0000_4000);
		wr(8'h1C, 32'h1234_5678);
		run(4'h4);
		rn(8'h20, 0.375 * 2.0 ** 31, 4);
		rn(8'h24, -0.125 * 2.0 ** 31, 4);
		rc(8'h1C, 32'h1234_5678);
		wr(8'h00, 32'h0000_0001);
		run(4'h4);
		rc(8'h1C, 32'hFFFF_E000);
		wr(8'h14, 32'h2000_0000);
		wr(8'h18, 32'h4000_0000);
		wr(8'h28, 32'h0000_0000);
		run(4'h4);
		rn(8'h1C, $atan(0.5) / $atan(1.0) * 8192.0, 8);
		finish_test();
	end
endmodule : vct_engine_tb
